// ---- mcsd_main_clock_stop.sv ----
// Main clock stop detector with fallback control, shared-vector causes and clock register protection
//
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module mcsd_main_clock_stop
	import mcsd_pkg::*;
#(
	parameter int WINDOW_CYC = STOP_WINDOW_CYC // Edge-free cycles that count as a stop
) (
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	// Register port
	input  wire mcsd_bus_s  bus,
	output var  logic [7:0] rd_data,
	// Main oscillator pin
	input  wire logic       main_osc_input,
	// Events from neighbouring blocks on sys_clk
	input  wire logic       watchdog_event,
	input  wire logic       vmon2_event,
	// Clock control outputs
	output var  logic       cpu_on_onchip_clk,
	output var  logic       low_speed_osc_halt,
	output var  logic       high_speed_osc_select,
	output var  logic       main_clock_halt,
	output var  logic       periph_clock_stop_in_wait,
	output var  logic [1:0] detect_enable_field,
	// Interrupt outputs
	output var  logic       shared_nmi_req,
	output var  logic       irq
);

	////////////////////////////////////////////////////////////////////////////////
	// Register state
	logic [7:0] clock_mode_reg_a;        // Wait and halt controls
	logic [7:0] clock_mode_reg_b;        // Low-speed oscillator control
	logic [7:0] osc_stop_ctrl_reg;       // Enable, selected and stopped bits
	logic [7:0] onchip_osc_ctrl_reg;     // Oscillator select
	logic [7:0] onchip_osc_ctrl_reg_b;   // Plain storage behind protection
	logic [7:0] onchip_osc_ctrl_reg_c;   // Plain storage behind protection
	logic [7:0] write_protect_reg;       // Write enable for clock registers
	logic [7:0] voltage_monitor_ctrl_reg; // Cause flags for the shared vector
	logic [2:0] int_status;              // Sticky events
	logic [2:0] int_mask;                // Enables onto irq

	logic [7:0] next_clock_mode_reg_a;
	logic [7:0] next_clock_mode_reg_b;
	logic [7:0] next_osc_stop_ctrl_reg;
	logic [7:0] next_onchip_osc_ctrl_reg;
	logic [7:0] next_onchip_osc_ctrl_reg_b;
	logic [7:0] next_onchip_osc_ctrl_reg_c;
	logic [7:0] next_write_protect_reg;
	logic [7:0] next_voltage_monitor_ctrl_reg;
	logic [2:0] next_int_status;
	logic [2:0] next_int_mask;
	logic [7:0] next_rd_data;
	logic       next_shared_nmi_req;
	logic       next_irq;

	// Decoded helpers
	logic       stop_seen;      // Edge-free window elapsed
	logic       armed;          // Detection enabled
	logic       stop_event;     // One cycle: a stop is being acted on
	logic       clk_wr_ok;      // Protected writes allowed
	logic       wr_prot;        // A write is taken while protected writes are allowed, at any offset
	logic       osc_cause;      // Stop detection cause for the shared vector
	logic [2:0] ev;             // Event pulses into the status register

	////////////////////////////////////////////////////////////////////////////////
	// Edge watcher on the main oscillator pin
	mcsd_stop_watch #(
		.WINDOW_CYC (WINDOW_CYC),
		.CNT_W      (8)
	) u_watch (
		.sys_clk        (sys_clk),
		.rst_n          (rst_n),
		.main_osc_input (main_osc_input),
		.stop_seen      (stop_seen)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Decode of detection state and bus access
	always_comb begin
		armed = (osc_stop_ctrl_reg[BIT_DET_EN_LO +: 2] == DET_ENABLED);
		// Act only while the CPU still runs from the main clock, so the event fires once
		stop_event = armed && !osc_stop_ctrl_reg[BIT_ONCHIP_SEL] && stop_seen;
		clk_wr_ok  = write_protect_reg[BIT_CLK_WR_EN];
		wr_prot    = bus.wr && clk_wr_ok;
		osc_cause  = osc_stop_ctrl_reg[BIT_STOPPED] ||
			(armed && osc_stop_ctrl_reg[BIT_ONCHIP_SEL]);
		ev                  = '0;
		ev[BIT_EV_OSC_STOP] = stop_event;
		ev[BIT_EV_WDT]      = watchdog_event;
		ev[BIT_EV_VMON]     = vmon2_event;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next register values; hardware sets win over software clears
	always_comb begin
		next_clock_mode_reg_a         = clock_mode_reg_a;
		next_clock_mode_reg_b         = clock_mode_reg_b;
		next_osc_stop_ctrl_reg        = osc_stop_ctrl_reg;
		next_onchip_osc_ctrl_reg      = onchip_osc_ctrl_reg;
		next_onchip_osc_ctrl_reg_b    = onchip_osc_ctrl_reg_b;
		next_onchip_osc_ctrl_reg_c    = onchip_osc_ctrl_reg_c;
		next_write_protect_reg        = write_protect_reg;
		next_voltage_monitor_ctrl_reg = voltage_monitor_ctrl_reg;
		next_int_mask                 = int_mask;
		next_int_status               = int_status;

		// Software writes
		if (bus.wr) begin
			case (bus.addr)
				OFS_PROTECT: begin
					next_write_protect_reg = {7'h00, bus.wdata[BIT_CLK_WR_EN]};
				end
				OFS_VMON_CTRL: begin
					// Cause flags are cleared by writing zero; a one write leaves them
					next_voltage_monitor_ctrl_reg = voltage_monitor_ctrl_reg & bus.wdata;
				end
				OFS_INT_MASK: begin
					next_int_mask = bus.wdata[2:0];
				end
				default: begin
					// Protected registers are handled below
				end
			endcase
		end

		// Writes behind the protect bit; refused writes are dropped silently
		if (wr_prot) begin
			case (bus.addr)
				OFS_CLK_MODE_A: begin
					next_clock_mode_reg_a = bus.wdata;
				end
				OFS_CLK_MODE_B: begin
					next_clock_mode_reg_b = bus.wdata;
				end
				OFS_OSC_STOP: begin
					// Enable and selected bits are plain; the stopped flag only clears
					next_osc_stop_ctrl_reg = {4'h0,
						osc_stop_ctrl_reg[BIT_STOPPED] & bus.wdata[BIT_STOPPED],
						bus.wdata[2:0]};
				end
				OFS_ONCHIP_A: begin
					next_onchip_osc_ctrl_reg = bus.wdata;
				end
				OFS_ONCHIP_B: begin
					next_onchip_osc_ctrl_reg_b = bus.wdata;
				end
				OFS_ONCHIP_C: begin
					next_onchip_osc_ctrl_reg_c = bus.wdata;
				end
				default: begin
					// Unprotected or unmapped offsets
				end
			endcase
		end

		// Status read clears, events set in the same cycle survive
		if (bus.rd && bus.addr == OFS_INT_STATUS) begin
			next_int_status = '0;
		end
		next_int_status = next_int_status | ev;

		// Fallback on a detected stop, no software involved
		if (stop_event) begin
			next_osc_stop_ctrl_reg[BIT_ONCHIP_SEL] = 1'b1;
			next_osc_stop_ctrl_reg[BIT_STOPPED]    = 1'b1;
			next_clock_mode_reg_b[BIT_LS_OSC_HALT] = 1'b0;
		end

		// Shared vector cause flags
		if (watchdog_event) begin
			next_voltage_monitor_ctrl_reg[BIT_WDT_CAUSE] = 1'b1;
		end
		if (vmon2_event) begin
			next_voltage_monitor_ctrl_reg[BIT_VMON_CAUSE] = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next output values: read data and interrupt lines
	always_comb begin
		next_rd_data = 8'h00; // Unmapped offsets and idle cycles read zero
		if (bus.rd) begin
			case (bus.addr)
				OFS_CLK_MODE_A: next_rd_data = clock_mode_reg_a;
				OFS_CLK_MODE_B: next_rd_data = clock_mode_reg_b;
				OFS_OSC_STOP:   next_rd_data = osc_stop_ctrl_reg;
				OFS_ONCHIP_A:   next_rd_data = onchip_osc_ctrl_reg;
				OFS_ONCHIP_B:   next_rd_data = onchip_osc_ctrl_reg_b;
				OFS_ONCHIP_C:   next_rd_data = onchip_osc_ctrl_reg_c;
				OFS_PROTECT:    next_rd_data = write_protect_reg;
				OFS_VMON_CTRL:  next_rd_data = voltage_monitor_ctrl_reg;
				OFS_INT_STATUS: next_rd_data = {5'h00, int_status};
				OFS_INT_MASK:   next_rd_data = {5'h00, int_mask};
				default:        next_rd_data = 8'h00;
			endcase
		end
		// One vector for all three causes; neither the mask nor any CPU flag gates it
		next_shared_nmi_req = osc_cause ||
			voltage_monitor_ctrl_reg[BIT_WDT_CAUSE] ||
			voltage_monitor_ctrl_reg[BIT_VMON_CAUSE];
		next_irq = |(next_int_status & next_int_mask);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			clock_mode_reg_a         <= RST_CLK_MODE_A;
			clock_mode_reg_b         <= RST_CLK_MODE_B;
			osc_stop_ctrl_reg        <= RST_OSC_STOP;
			onchip_osc_ctrl_reg      <= RST_ONCHIP;
			onchip_osc_ctrl_reg_b    <= RST_ONCHIP;
			onchip_osc_ctrl_reg_c    <= RST_ONCHIP;
			write_protect_reg        <= RST_PROTECT;
			voltage_monitor_ctrl_reg <= RST_VMON_CTRL;
			int_status               <= RST_INT;
			int_mask                 <= RST_INT;
			rd_data                  <= 8'h00;
			shared_nmi_req           <= 1'b0;
			irq                      <= 1'b0;
		end else begin
			clock_mode_reg_a         <= next_clock_mode_reg_a;
			clock_mode_reg_b         <= next_clock_mode_reg_b;
			osc_stop_ctrl_reg        <= next_osc_stop_ctrl_reg;
			onchip_osc_ctrl_reg      <= next_onchip_osc_ctrl_reg;
			onchip_osc_ctrl_reg_b    <= next_onchip_osc_ctrl_reg_b;
			onchip_osc_ctrl_reg_c    <= next_onchip_osc_ctrl_reg_c;
			write_protect_reg        <= next_write_protect_reg;
			voltage_monitor_ctrl_reg <= next_voltage_monitor_ctrl_reg;
			int_status               <= next_int_status;
			int_mask                 <= next_int_mask;
			rd_data                  <= next_rd_data;
			shared_nmi_req           <= next_shared_nmi_req;
			irq                      <= next_irq;
		end
	end

	// Control outputs mirror register bits, so they come straight from flip-flops
	assign cpu_on_onchip_clk         = osc_stop_ctrl_reg[BIT_ONCHIP_SEL];
	assign low_speed_osc_halt        = clock_mode_reg_b[BIT_LS_OSC_HALT];
	assign high_speed_osc_select     = onchip_osc_ctrl_reg[BIT_HS_OSC_SEL];
	assign main_clock_halt           = clock_mode_reg_a[BIT_MAIN_HALT];
	assign periph_clock_stop_in_wait = clock_mode_reg_a[BIT_PERIPH_STOP_WAIT];
	assign detect_enable_field       = osc_stop_ctrl_reg[BIT_DET_EN_LO +: 2];

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	arm_needs_11_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(stop_seen && !cpu_on_onchip_clk && detect_enable_field != DET_ENABLED)
			|=> !osc_stop_ctrl_reg[BIT_STOPPED] || $past(osc_stop_ctrl_reg[BIT_STOPPED]))
		else $error("stop flagged while detection was not armed");

	fallback_state_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(stop_seen && armed && !cpu_on_onchip_clk) |=> cpu_on_onchip_clk && !low_speed_osc_halt)
		else $error("fallback clock state not entered on a stop");

	stopped_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		stop_event |=> osc_stop_ctrl_reg[BIT_STOPPED])
		else $error("stopped flag missing after a stop");

	stop_request_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		stop_event |=> int_status[BIT_EV_OSC_STOP] && (irq || !int_mask[BIT_EV_OSC_STOP]))
		else $error("stop event not latched in status");

	nmi_unmasked_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		stop_event |-> ##2 shared_nmi_req)
		else $error("shared vector request not raised after a stop");

	// Causes spelled out from the register fields, not from the internal cause term
	cause_term_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		shared_nmi_req == $past(osc_stop_ctrl_reg[BIT_STOPPED] ||
			(detect_enable_field == DET_ENABLED && cpu_on_onchip_clk) ||
			voltage_monitor_ctrl_reg[BIT_WDT_CAUSE] || voltage_monitor_ctrl_reg[BIT_VMON_CAUSE]))
		else $error("shared vector request does not follow the causes");

	watchdog_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		watchdog_event |=> voltage_monitor_ctrl_reg[BIT_WDT_CAUSE] ##1 shared_nmi_req)
		else $error("watchdog cause flag not set");

	vmon_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		vmon2_event |=> voltage_monitor_ctrl_reg[BIT_VMON_CAUSE] ##1 shared_nmi_req)
		else $error("voltage monitor cause flag not set");

	protect_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(bus.wr && !clk_wr_ok && bus.addr == OFS_OSC_STOP) |=> $stable(detect_enable_field))
		else $error("protected register changed while write enable was low");

	// Halt and wait controls must not move on a refused write
	protect_mode_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(bus.wr && !clk_wr_ok && bus.addr == OFS_CLK_MODE_A) |=> $stable(clock_mode_reg_a))
		else $error("clock mode register changed while write enable was low");

	// The stop event is sticky until a status read takes it away
	status_sticky_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		int_status[BIT_EV_OSC_STOP] && !(bus.rd && bus.addr == OFS_INT_STATUS) |=> int_status[BIT_EV_OSC_STOP])
		else $error("stop status bit lost without a status read");

	// Hardware never switches back to the main clock on its own
	onchip_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cpu_on_onchip_clk && !(bus.wr && clk_wr_ok && bus.addr == OFS_OSC_STOP) |=> cpu_on_onchip_clk)
		else $error("on-chip clock selection dropped without a software write");

	// Only a permitted software write may take the stopped flag away
	stopped_sticky_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		osc_stop_ctrl_reg[BIT_STOPPED] && !(bus.wr && clk_wr_ok && bus.addr == OFS_OSC_STOP)
			|=> osc_stop_ctrl_reg[BIT_STOPPED])
		else $error("stopped flag cleared without a software write");

	stop_seen_c: cover property (@(posedge sys_clk) disable iff (!rst_n) stop_event ##2 irq);
	refused_wr_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
		bus.wr && !clk_wr_ok && bus.addr == OFS_CLK_MODE_A);
	wdt_cause_c: cover property (@(posedge sys_clk) disable iff (!rst_n) watchdog_event ##2 shared_nmi_req);
	half_armed_c: cover property (@(posedge sys_clk) disable iff (!rst_n) stop_seen && detect_enable_field == 2'h1);
	read_clear_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
		bus.rd && bus.addr == OFS_INT_STATUS && int_status != 3'h0);

endmodule // mcsd_main_clock_stop

`default_nettype wire

// ---- mcsd_osc_model.sv ----
// Behavioural model of the external main clock oscillator feeding the stop detector
`timescale 1ns/1ps
`default_nettype none

module mcsd_osc_model (
	// Control from the bench
	input  wire logic run,
	// Oscillator pin
	output var  logic main_osc_input
);
	// Half period 200 ns gives 2.5 MHz, above the lowest usable rate
	localparam int HALF_NS = 200;

	////////////////////////////////////////////////////////////////////////////////
	// A stopped crystal just freezes at its last level, so no edge is left to see
	initial begin
		main_osc_input = 1'b0;
		forever begin
			#(HALF_NS);
			if (run) begin
				main_osc_input = ~main_osc_input;
			end
		end
	end
endmodule // mcsd_osc_model

`default_nettype wire

// ---- mcsd_pkg.sv ----
// Package with offsets, field positions, reset values and timing of the main clock stop detector
`default_nettype none

package mcsd_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Clock and timing
	localparam int CLK_PERIOD_NS   = 100;  // sys_clk period at 10 MHz
	localparam int STOP_WINDOW_NS  = 2000; // Longest gap without a main clock edge before a stop
	// Least time, so rounded up to whole cycles
	localparam int STOP_WINDOW_CYC = (STOP_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////////////////
	// Register offsets on the plain register port
	localparam logic [7:0] OFS_CLK_MODE_A  = 8'h00; // clock_mode_reg_a
	localparam logic [7:0] OFS_CLK_MODE_B  = 8'h01; // clock_mode_reg_b
	localparam logic [7:0] OFS_OSC_STOP    = 8'h02; // osc_stop_ctrl_reg
	localparam logic [7:0] OFS_ONCHIP_A    = 8'h03; // onchip_osc_ctrl_reg
	localparam logic [7:0] OFS_ONCHIP_B    = 8'h04; // Second on-chip oscillator control
	localparam logic [7:0] OFS_ONCHIP_C    = 8'h05; // Third on-chip oscillator control
	localparam logic [7:0] OFS_PROTECT     = 8'h06; // write_protect_reg
	localparam logic [7:0] OFS_VMON_CTRL   = 8'h07; // voltage_monitor_ctrl_reg
	localparam logic [7:0] OFS_INT_STATUS  = 8'h08; // Sticky event status, cleared by read
	localparam logic [7:0] OFS_INT_MASK    = 8'h09; // Interrupt mask

	////////////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int BIT_PERIPH_STOP_WAIT = 2; // periph_clock_stop_in_wait in mode reg a
	localparam int BIT_MAIN_HALT        = 5; // main_clock_halt in mode reg a
	localparam int BIT_LS_OSC_HALT      = 4; // low_speed_osc_halt in mode reg b
	localparam int BIT_DET_EN_LO        = 0; // detect_enable_field, two bits
	localparam int BIT_ONCHIP_SEL       = 2; // onchip_clock_selected
	localparam int BIT_STOPPED          = 3; // main_clock_stopped_flag
	localparam int BIT_HS_OSC_SEL       = 1; // high_speed_osc_select in onchip reg a
	localparam int BIT_CLK_WR_EN        = 0; // clock_reg_write_enable in protect reg
	localparam int BIT_VMON_CAUSE       = 2; // voltage_monitor_cause_flag
	localparam int BIT_WDT_CAUSE        = 3; // watchdog_cause_flag
	localparam int BIT_EV_OSC_STOP      = 0; // Status and mask: stop detected
	localparam int BIT_EV_WDT           = 1; // Status and mask: watchdog cause
	localparam int BIT_EV_VMON          = 2; // Status and mask: voltage monitor cause

	localparam logic [1:0] DET_ENABLED  = 2'h3; // Detection armed
	localparam logic [1:0] DET_DISABLED = 2'h0; // Detection off

	////////////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [7:0] RST_CLK_MODE_A = 8'h00;
	localparam logic [7:0] RST_CLK_MODE_B = 8'h10; // Low-speed oscillator halted
	localparam logic [7:0] RST_OSC_STOP   = 8'h00;
	localparam logic [7:0] RST_ONCHIP     = 8'h00;
	localparam logic [7:0] RST_PROTECT    = 8'h00;
	localparam logic [7:0] RST_VMON_CTRL  = 8'h00;
	localparam logic [2:0] RST_INT        = 3'h0;

	////////////////////////////////////////////////////////////////////////////////
	// Register port request, one cycle per access
	typedef struct packed {
		logic [7:0] addr;  // Register offset
		logic [7:0] wdata; // Write data
		logic       wr;    // Write strobe
		logic       rd;    // Read strobe
	} mcsd_bus_s;

endpackage

`default_nettype wire

// ---- mcsd_stop_watch.sv ----
// Watches the synchronised main oscillator input and flags a missing edge window
`timescale 1ns/1ps
`default_nettype none

module mcsd_stop_watch
	import mcsd_pkg::*;
#(
	parameter int WINDOW_CYC = STOP_WINDOW_CYC, // Cycles without an edge that mean a stop
	parameter int CNT_W      = 8                // Counter width, must hold WINDOW_CYC
) (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rst_n,
	// Main oscillator pin
	input  wire logic main_osc_input,
	// Stop indication
	output var  logic stop_seen
);

	localparam logic [CNT_W-1:0] WIN = CNT_W'(WINDOW_CYC); // Window at counter width

	logic             sync_a;        // First synchroniser stage, read only by sync_b
	logic             sync_b;        // Second synchroniser stage
	logic             sync_c;        // Delayed copy for edge detection
	logic [CNT_W-1:0] gap_cnt;       // Cycles since the last edge
	logic [CNT_W-1:0] next_gap_cnt;
	logic             next_stop_seen;
	logic             edge_seen;     // Any edge of the main clock

	////////////////////////////////////////////////////////////////////////////////
	// Next values: restart on an edge, saturate at the window
	always_comb begin
		edge_seen      = sync_b ^ sync_c;
		next_gap_cnt   = gap_cnt;
		next_stop_seen = 1'b0;
		if (edge_seen) begin
			next_gap_cnt = '0;
		end else if (gap_cnt != WIN) begin
			next_gap_cnt = gap_cnt + CNT_W'(1);
		end
		// A 10 MHz sample rate cannot see edges of a clock near or above 5 MHz; shorten nothing here
		next_stop_seen = (next_gap_cnt == WIN);
	end

	// Registers: synchroniser, counter and flag
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			sync_a    <= 1'b0;
			sync_b    <= 1'b0;
			sync_c    <= 1'b0;
			gap_cnt   <= '0;
			stop_seen <= 1'b0;
		end else begin
			sync_a    <= main_osc_input;
			sync_b    <= sync_a;
			sync_c    <= sync_b;
			gap_cnt   <= next_gap_cnt;
			stop_seen <= next_stop_seen;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	edge_clears_stop_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		edge_seen |=> !stop_seen)
		else $error("stop flag set right after a main clock edge");

	window_full_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$rose(stop_seen) |-> $past(gap_cnt) == WIN - CNT_W'(1))
		else $error("stop flag rose before the window was full");

endmodule // mcsd_stop_watch

`default_nettype wire

// ---- tb.sv ----
// Self-checking testbench of the main clock stop detector
`timescale 1ns/1ps
`default_nettype none

module tb;
	import mcsd_pkg::*;
	localparam int WIN = 4; // Short stop window keeps the run brief
	logic       sys_clk = 1'b0;
	logic       rst_n   = 1'b0;
	mcsd_bus_s  bus     = '0;
	logic       wdt_ev  = 1'b0;
	logic       vmon_ev = 1'b0;
	logic       run     = 1'b1;
	logic       osc, cpu, lso, hss, mch, pcw, nmi, irq, rd_seen = 1'b0;
	logic [1:0] den;
	logic [7:0] rd_data, rv;
	logic [7:0] exp_q[$]; // Expected read data, oldest first
	int         n_fail = 0;
	int         total_checks = 0;

	mcsd_osc_model i_mcsd_osc_model (.run(run), .main_osc_input(osc));
	mcsd_main_clock_stop #(.WINDOW_CYC(WIN)) i_mcsd_main_clock_stop (.sys_clk(sys_clk), .rst_n(rst_n),
		.bus(bus), .rd_data(rd_data), .main_osc_input(osc), .watchdog_event(wdt_ev), .vmon2_event(vmon_ev),
		.cpu_on_onchip_clk(cpu), .low_speed_osc_halt(lso), .high_speed_osc_select(hss), .main_clock_halt(mch),
		.periph_clock_stop_in_wait(pcw), .detect_enable_field(den), .shared_nmi_req(nmi), .irq(irq));

	initial begin
		forever #50 sys_clk = ~sys_clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Compare and count
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// One-cycle write, strobe dropped on the next edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk) bus <= '0;
	endtask
	// One-cycle read, expectation noted for the monitor
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		@(posedge sys_clk) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk) bus <= '0;
	endtask
	// Wait n edges, then let their updates land
	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Read data stands only in the cycle after the strobe
	always @(posedge sys_clk) begin
		if (rd_seen) begin
			chk(rd_data, exp_q.pop_front());
		end
		rd_seen <= bus.rd;
	end

	// Watchdog far beyond the expected run of under two hundred cycles
	initial begin
		#1_000_000;
		n_fail++;
		test_done();
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		void'($urandom(32'h28cd_f713));
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		settle(1);
		chk({7'h00, lso}, 8'h01);
		for (int a = 0; a < 11; a++) begin
			rd(a[7:0], (a == 1) ? RST_CLK_MODE_B : 8'h00);
		end
		wr(OFS_OSC_STOP, 8'h03);
		wr(OFS_CLK_MODE_A, 8'h24);
		rd(OFS_OSC_STOP, 8'h00);
		settle(1);
		chk({mch, pcw, den}, 8'h00);
		wr(OFS_PROTECT, 8'h01);
		wr(OFS_ONCHIP_A, 8'h02);
		settle(1);
		chk({7'h00, hss}, 8'h01);
		// Detection off before the halt bit moves, peripheral clock stopped in wait
		wr(OFS_OSC_STOP, 8'h00);
		wr(OFS_CLK_MODE_A, 8'h24);
		settle(1);
		chk({mch, pcw, den}, 8'h0c);
		wr(OFS_CLK_MODE_A, 8'h00);
		rd(OFS_CLK_MODE_A, 8'h00);
		for (int i = 0; i < 4; i++) begin
			rv = 8'($urandom());
			wr(OFS_ONCHIP_B + i[7:0] % 2, rv);
			rd(OFS_ONCHIP_B + i[7:0] % 2, rv);
		end
		// Half-armed field must not detect
		wr(OFS_OSC_STOP, 8'h01);
		run = 1'b0;
		settle(30);
		chk({cpu, nmi}, 8'h00);
		run = 1'b1;
		settle(10);
		wr(OFS_INT_MASK, 8'h07);
		wr(OFS_OSC_STOP, 8'h03);
		settle(1);
		chk({6'h00, den}, 8'h03);
		run = 1'b0;
		for (int i = 0; i < 60; i++) begin
			@(posedge sys_clk);
			if (cpu === 1'b1) break;
		end
		settle(2);
		chk({cpu, lso, nmi, irq}, 8'h0b);
		rd(OFS_OSC_STOP, 8'h0f);
		rd(OFS_CLK_MODE_B, 8'h00);
		rd(OFS_INT_STATUS, 8'h01);
		rd(OFS_INT_STATUS, 8'h00);
		settle(2);
		chk({irq, nmi}, 8'h01);
		// Software picks the low-speed on-chip oscillator as fallback
		wr(OFS_ONCHIP_A, 8'h00);
		wr(OFS_OSC_STOP, 8'h0f);
		rd(OFS_OSC_STOP, 8'h0f);
		chk({7'h00, hss}, 8'h00);
		// Oscillator back, software switches back itself
		run = 1'b1;
		settle(10);
		chk({7'h00, cpu}, 8'h01);
		wr(OFS_OSC_STOP, 8'h03);
		settle(2);
		chk({cpu, nmi}, 8'h00);
		// Shared vector causes with interrupt masked off
		wr(OFS_INT_MASK, 8'h00);
		@(posedge sys_clk) wdt_ev <= 1'b1;
		@(posedge sys_clk) wdt_ev <= 1'b0;
		settle(2);
		chk({irq, nmi}, 8'h01);
		rd(OFS_VMON_CTRL, 8'h08);
		rd(OFS_INT_STATUS, 8'h02);
		wr(OFS_VMON_CTRL, 8'h00);
		@(posedge sys_clk) vmon_ev <= 1'b1;
		@(posedge sys_clk) vmon_ev <= 1'b0;
		settle(2);
		chk({7'h00, nmi}, 8'h01);
		rd(OFS_VMON_CTRL, 8'h04);
		rd(OFS_INT_STATUS, 8'h04);
		settle(3);
		test_done();
	end
endmodule // tb

`default_nettype wire
